// File: bme_cfg.svh
// constants for the bit-manipulation execution unit
// assumes a single 20 MHz core clock and an internal memory/io bus answering in the cycle after the read strobe
`ifndef BME_CFG_SVH
`define BME_CFG_SVH
// ==================================================================
// operation codes
`define BME_OP_BIT_LOAD 5'h01
`define BME_OP_BIT_STORE 5'h02
`define BME_OP_SET 5'h03
`define BME_OP_CLR 5'h04
`define BME_OP_BBZ 5'h05
`define BME_OP_BBO 5'h06
`define BME_OP_BSB 5'h07
`define BME_OP_WAIT_HI 5'h08
`define BME_OP_WAIT_LO 5'h09
`define BME_OP_SWAP 5'h0A
`define BME_OP_POP 5'h0B
`define BME_OP_PUSH 5'h0C
`define BME_OP_BANK_RD 5'h0D
`define BME_OP_EXT 5'h0E
`define BME_OP_EXTW 5'h0F
`define BME_OP_ZERO_EXTEND_BYTE 5'h10
`define BME_OP_ZEXTW 5'h11
// ==================================================================
// addressing forms
`define BME_AM_DIR 2'h0
`define BME_AM_A16 2'h1
`define BME_AM_IO 2'h2
// bank register selects
`define BME_BRG_DTB 3'h1
`define BME_BRG_DPR 3'h6
// ==================================================================
// cycle counts
`define BME_CYC_LOAD 8'h05
`define BME_CYC_LOAD_IO 8'h04
`define BME_CYC_RMW 8'h07
`define BME_CYC_RMW_IO 8'h06
`define BME_CYC_BR_T 8'h08
`define BME_CYC_BR_N 8'h07
`define BME_CYC_BRIO_T 8'h07
`define BME_CYC_BRIO_N 8'h06
`define BME_CYC_BSB_T 8'h0A
`define BME_CYC_BSB_N 8'h09
`define BME_CYC_SWAP 8'h03
`define BME_CYC_POP_BASE 8'h07
`define BME_CYC_PUSH_BASE 8'h1D
`define BME_CYC_PUSH_EMPTY 8'h08
`define BME_CYC_BANK1 8'h01
`define BME_CYC_BANK2 8'h02
`define BME_CYC_EXT 8'h01
`define BME_CYC_EXTW 8'h02
`define BME_CYC_ZERO_EXTEND_BYTE 8'h01
`endif

// File: bme_mem_model.sv
// behavioural memory and io space on the unit's byte bus
// assumes read data is wanted only in the cycle after a read strobe
`timescale 1ns/100ps
`default_nettype none
module bme_mem (
   // clock
   input wire logic CLK,
   // bus from the unit
   input wire logic BUS_RD,
   input wire logic BUS_WR,
   input wire logic BUS_IO,
   input wire logic [15:0] BUS_ADDR,
   input wire logic [7:0] BUS_WDATA,
   output logic [7:0] BUS_RDATA
);
   // ==================================================================
   // io space in the upper half; only low address bits decoded
   logic [7:0] mem [0:255];
   initial BUS_RDATA = 8'h5A;
   // data toggles outside its valid cycle so a late sample shows up
   always @(posedge CLK) begin
      if (BUS_RD) begin
         BUS_RDATA <= mem[{BUS_IO, BUS_ADDR[6:0]}];
      end else begin
         BUS_RDATA <= ~BUS_RDATA;
      end
      if (BUS_WR) begin
         mem[{BUS_IO, BUS_ADDR[6:0]}] <= BUS_WDATA;
      end
   end
endmodule : bme_mem
`default_nettype wire

// File: bme_pkg.sv
// types for the bit-manipulation execution unit
// assumes bme_cfg.svh supplies the numeric codes
package bme_pkg;
   // ==================================================================
   // request from the decoder
   typedef struct packed {
      logic [4:0] op;
      logic [1:0] amode;
      logic [15:0] addr;
      logic [2:0] bitpos;
      logic [7:0] rlist;
      logic [2:0] bank_sel;
   } bme_req_t;
   // flag group
   typedef struct packed {
      logic n;
      logic z;
   } bme_flags_t;
   // controller states
   typedef enum logic [4:0] {
      BME_IDLE = 5'h01,
      BME_READ = 5'h02,
      BME_WRITE = 5'h04,
      BME_COUNT = 5'h08,
      BME_WAIT = 5'h10
   } bme_state_t;
endpackage : bme_pkg

// File: bme_unit.sv
// execution unit for bit, accumulator, stack-list and bank-register moves
// assumes bus read data is valid in the cycle after BUS_RD; bus writes take one cycle
`timescale 1ns/100ps
`default_nettype none
`include "bme_cfg.svh"
module bme_unit (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // decoder request
   input wire logic START,
   input wire bme_pkg::bme_req_t REQ,
   input wire logic [31:0] ACC_IN,
   input wire logic [7:0] BANK_IN,
   output logic BUSY,
   output logic DONE,
   // results
   output logic [31:0] ACC_OUT,
   output logic ACC_WE,
   output bme_pkg::bme_flags_t FLAGS,
   output logic FLAG_N_WE,
   output logic FLAG_Z_WE,
   output logic BRANCH,
   // memory and io bus
   output logic BUS_RD,
   output logic BUS_WR,
   output logic BUS_IO,
   output logic [15:0] BUS_ADDR,
   output logic [7:0] BUS_WDATA,
   input wire logic [7:0] BUS_RDATA
);
   bme_pkg::bme_state_t state;
   bme_pkg::bme_req_t req;
   logic [7:0] cnt;
   logic [7:0] total;
   logic [7:0] rdbyte;
   logic [7:0] rd_src;
   logic bitv;
   logic [7:0] next_total;
   logic [7:0] next_wbyte;

   // ==================================================================
   // helpers
   // population count of a register list
   function automatic logic [7:0] pop_count(input logic [7:0] l);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 8; i++) begin
         c = c + {7'h00, l[i]};
      end
      return c;
   endfunction : pop_count

   // highest set register number in a list
   function automatic logic [7:0] last_reg(input logic [7:0] l);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (l[i]) begin
            r = 8'(i);
         end
      end
      return r;
   endfunction : last_reg

   // io form or memory form cycle choice
   function automatic logic [7:0] pick(input logic io, input logic [7:0] a, input logic [7:0] b);
      return io ? b : a;
   endfunction : pick

   // ==================================================================
   // total cycle count for the request, known once the bit is read
   always_comb begin
      logic io;
      io = (req.amode == `BME_AM_IO);
      next_total = 8'h01;
      unique case (req.op)
         `BME_OP_BIT_LOAD: next_total = pick(io, `BME_CYC_LOAD, `BME_CYC_LOAD_IO);
         `BME_OP_BIT_STORE: next_total = pick(io, `BME_CYC_RMW, `BME_CYC_RMW_IO);
         `BME_OP_SET, `BME_OP_CLR: next_total = `BME_CYC_RMW;
         `BME_OP_BBZ: next_total = io ? (!bitv ? `BME_CYC_BRIO_T : `BME_CYC_BRIO_N)
            : (!bitv ? `BME_CYC_BR_T : `BME_CYC_BR_N);
         `BME_OP_BBO: next_total = io ? (bitv ? `BME_CYC_BRIO_T : `BME_CYC_BRIO_N)
            : (bitv ? `BME_CYC_BR_T : `BME_CYC_BR_N);
         `BME_OP_BSB: next_total = bitv ? `BME_CYC_BSB_T : `BME_CYC_BSB_N;
         `BME_OP_SWAP: next_total = `BME_CYC_SWAP;
         `BME_OP_POP: next_total = (req.rlist == 8'h00) ? `BME_CYC_POP_BASE
            : 8'(`BME_CYC_POP_BASE + 8'h03 * pop_count(req.rlist) + 8'h02 * last_reg(req.rlist));
         `BME_OP_PUSH: next_total = (req.rlist == 8'h00) ? `BME_CYC_PUSH_EMPTY
            : 8'(`BME_CYC_PUSH_BASE + 8'h03 * pop_count(req.rlist) - 8'h03 * last_reg(req.rlist));
         `BME_OP_BANK_RD: next_total = (req.bank_sel == `BME_BRG_DTB || req.bank_sel == `BME_BRG_DPR)
            ? `BME_CYC_BANK2 : `BME_CYC_BANK1;
         `BME_OP_EXT, `BME_OP_ZERO_EXTEND_BYTE, `BME_OP_ZEXTW: next_total = `BME_CYC_EXT;
         `BME_OP_EXTW: next_total = `BME_CYC_EXTW;
         default: next_total = 8'h01;
      endcase
   end

   // modified byte for the read-modify-write forms
   always_comb begin
      next_wbyte = rd_src;
      unique case (req.op)
         `BME_OP_BIT_STORE: next_wbyte[req.bitpos] = ACC_IN[0];
         `BME_OP_SET, `BME_OP_BSB: next_wbyte[req.bitpos] = 1'b1;
         `BME_OP_CLR: next_wbyte[req.bitpos] = 1'b0;
         default: next_wbyte = rd_src;
      endcase
   end

   // the memory answers one cycle after the strobe cycle, so the byte is taken live in write and wait
   assign rd_src = (state == bme_pkg::BME_WRITE || state == bme_pkg::BME_WAIT) ? BUS_RDATA : rdbyte;
   assign bitv = rd_src[req.bitpos];

   // ==================================================================
   // sequencer: read phase, optional write, then count out the cycle budget
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state <= bme_pkg::BME_IDLE;
         req <= '0;
         cnt <= 8'h00;
         total <= 8'h00;
         rdbyte <= 8'h00;
      end else begin
         unique case (state)
            bme_pkg::BME_IDLE: begin
               if (START) begin
                  req <= REQ;
                  cnt <= 8'h01;
                  state <= (REQ.op <= `BME_OP_WAIT_LO) ? bme_pkg::BME_READ : bme_pkg::BME_COUNT;
               end
            end
            bme_pkg::BME_READ: begin
               // read data is not yet valid here; it stands in the following cycle
               cnt <= cnt + 8'h01;
               if (req.op == `BME_OP_WAIT_HI || req.op == `BME_OP_WAIT_LO) begin
                  state <= bme_pkg::BME_WAIT;
               end else begin
                  state <= bme_pkg::BME_WRITE;
               end
            end
            bme_pkg::BME_WRITE: begin
               rdbyte <= BUS_RDATA;
               total <= next_total;
               cnt <= cnt + 8'h01;
               state <= bme_pkg::BME_COUNT;
            end
            bme_pkg::BME_WAIT: begin
               // keep sampling until the io bit reaches the wanted level
               if ((req.op == `BME_OP_WAIT_HI) == bitv) begin
                  state <= bme_pkg::BME_IDLE;
               end else begin
                  state <= bme_pkg::BME_READ;
               end
            end
            bme_pkg::BME_COUNT: begin
               if (cnt == 8'h01 && req.op > `BME_OP_WAIT_LO) begin
                  total <= next_total;
               end
               cnt <= cnt + 8'h01;
               if (cnt >= ((cnt == 8'h01 && req.op > `BME_OP_WAIT_LO) ? next_total : total)) begin
                  state <= bme_pkg::BME_IDLE;
               end
            end
            default: state <= bme_pkg::BME_IDLE;
         endcase
      end
   end

   // ==================================================================
   // bus strobes: one read (repeated by the wait forms until the level is seen), then one write for read-modify-write forms
   logic is_rmw;
   assign is_rmw = (req.op == `BME_OP_BIT_STORE) || (req.op == `BME_OP_SET)
      || (req.op == `BME_OP_CLR) || (req.op == `BME_OP_BSB);
   always_ff @(posedge CLK) begin
      if (SRST) begin
         BUS_RD <= 1'b0;
         BUS_WR <= 1'b0;
         BUS_IO <= 1'b0;
         BUS_ADDR <= 16'h0000;
         BUS_WDATA <= 8'h00;
      end else begin
         BUS_RD <= (state == bme_pkg::BME_IDLE && START && REQ.op <= `BME_OP_WAIT_LO && REQ.op != 5'h00)
            || (state == bme_pkg::BME_WAIT && ((req.op == `BME_OP_WAIT_HI) != bitv));
         BUS_WR <= (state == bme_pkg::BME_READ) ? 1'b0 : 1'b0;
         if (state == bme_pkg::BME_IDLE && START) begin
            BUS_ADDR <= REQ.addr;
            BUS_IO <= (REQ.amode == `BME_AM_IO);
         end
         // write leaves in the same cycle as the flag update, keeping the access atomic
         if (state == bme_pkg::BME_WRITE && is_rmw) begin
            BUS_WR <= 1'b1;
            BUS_WDATA <= next_wbyte;
         end
      end
   end

   // ==================================================================
   // accumulator, flag and branch results, presented in the first cycle of the count phase
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ACC_OUT <= 32'h0000_0000;
         ACC_WE <= 1'b0;
         FLAGS <= '0;
         FLAG_N_WE <= 1'b0;
         FLAG_Z_WE <= 1'b0;
         BRANCH <= 1'b0;
      end else begin
         ACC_WE <= 1'b0;
         FLAG_N_WE <= 1'b0;
         FLAG_Z_WE <= 1'b0;
         BRANCH <= 1'b0;
         if (state == bme_pkg::BME_WRITE) begin
            unique case (req.op)
               `BME_OP_BIT_LOAD: begin
                  ACC_OUT <= {ACC_IN[31:16], 8'h00, 7'h00, bitv};
                  ACC_WE <= 1'b1;
               end
               `BME_OP_BIT_STORE: begin
                  FLAGS <= '{n: ACC_IN[0], z: !ACC_IN[0]};
                  FLAG_N_WE <= 1'b1;
                  FLAG_Z_WE <= 1'b1;
               end
               `BME_OP_BBZ: begin
                  FLAGS.z <= !bitv;
                  FLAG_Z_WE <= 1'b1;
                  BRANCH <= !bitv;
               end
               `BME_OP_BBO, `BME_OP_BSB: begin
                  FLAGS.z <= !bitv;
                  FLAG_Z_WE <= 1'b1;
                  BRANCH <= bitv;
               end
               default: ACC_WE <= 1'b0;
            endcase
         end else if (state == bme_pkg::BME_IDLE && START) begin
            ACC_WE <= (REQ.op >= `BME_OP_SWAP) && (REQ.op != `BME_OP_POP) && (REQ.op != `BME_OP_PUSH);
            unique case (REQ.op)
               `BME_OP_SWAP: ACC_OUT <= {ACC_IN[31:16], ACC_IN[7:0], ACC_IN[15:8]};
               `BME_OP_BANK_RD: ACC_OUT <= {ACC_IN[31:16], 8'h00, BANK_IN};
               `BME_OP_EXT: begin
                  ACC_OUT <= {ACC_IN[31:16], {8{ACC_IN[7]}}, ACC_IN[7:0]};
                  FLAGS <= '{n: ACC_IN[7], z: ACC_IN[7:0] == 8'h00};
                  FLAG_N_WE <= 1'b1;
                  FLAG_Z_WE <= 1'b1;
               end
               `BME_OP_EXTW: begin
                  ACC_OUT <= {{16{ACC_IN[15]}}, ACC_IN[15:0]};
                  FLAGS <= '{n: ACC_IN[15], z: ACC_IN[15:0] == 16'h0000};
                  FLAG_N_WE <= 1'b1;
                  FLAG_Z_WE <= 1'b1;
               end
               `BME_OP_ZERO_EXTEND_BYTE: begin
                  ACC_OUT <= {ACC_IN[31:16], 8'h00, ACC_IN[7:0]};
                  FLAGS <= '{n: 1'b0, z: ACC_IN[7:0] == 8'h00};
                  FLAG_N_WE <= 1'b1;
                  FLAG_Z_WE <= 1'b1;
               end
               `BME_OP_ZEXTW: begin
                  ACC_OUT <= {16'h0000, ACC_IN[15:0]};
                  FLAGS <= '{n: 1'b0, z: ACC_IN[15:0] == 16'h0000};
                  FLAG_N_WE <= 1'b1;
                  FLAG_Z_WE <= 1'b1;
               end
               default: ACC_OUT <= ACC_OUT;
            endcase
         end
      end
   end

   // handshake: busy while sequencing, done in the last cycle of the budget or when the wait ends
   assign BUSY = (state != bme_pkg::BME_IDLE);
   assign DONE = (state == bme_pkg::BME_COUNT && cnt >= ((cnt == 8'h01 && req.op > `BME_OP_WAIT_LO)
      ? next_total : total))
      || (state == bme_pkg::BME_WAIT && ((req.op == `BME_OP_WAIT_HI) == bitv));
endmodule : bme_unit
`default_nettype wire

// File: bme_unit_assertions.sv
// checker for the bit-manipulation execution unit
// assumes the ports of bme_unit and the codes of bme_cfg.svh
`timescale 1ns/100ps
`default_nettype none
`include "bme_cfg.svh"
module bme_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // request and status
   input wire logic START,
   input wire bme_pkg::bme_req_t REQ,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic FLAG_N_WE,
   input wire logic FLAG_Z_WE,
   // bus
   input wire logic BUS_RD,
   input wire logic BUS_WR,
   input wire logic [15:0] BUS_ADDR,
   input wire logic [7:0] BUS_WDATA
);
   // ==================================================================
   // accepted request, and no flag write in this cycle
   wire go = START && !BUSY;
   wire nf = !FLAG_N_WE && !FLAG_Z_WE;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   property p_load;
      go && REQ.op == `BME_OP_BIT_LOAD && REQ.amode == `BME_AM_IO |=> !DONE[*3] ##1 DONE;
   endproperty
   a_load: assert property (p_load) else $error("bit load length wrong");
   property p_store;
      go && REQ.op == `BME_OP_BIT_STORE && REQ.amode != `BME_AM_IO |=> !DONE[*6] ##1 DONE;
   endproperty
   a_store: assert property (p_store) else $error("bit store length wrong");
   // read first, write back two cycles later
   property p_set;
      go && REQ.op == `BME_OP_SET |=> BUS_RD && BUS_ADDR == $past(REQ.addr) ##2 BUS_WR && BUS_WDATA[$past(REQ.bitpos, 3)];
   endproperty
   a_set: assert property (p_set) else $error("bit set write wrong");
   property p_clr;
      go && REQ.op == `BME_OP_CLR |=> nf[*2] ##1 BUS_WR && !BUS_WDATA[$past(REQ.bitpos, 3)];
   endproperty
   a_clr: assert property (p_clr) else $error("bit clear write wrong");
   property p_brm;
      go && (REQ.op == `BME_OP_BBZ || REQ.op == `BME_OP_BBO) && REQ.amode != `BME_AM_IO |=> !DONE[*6] ##[1:2] DONE;
   endproperty
   a_brm: assert property (p_brm) else $error("bit branch length wrong");
   property p_bsb;
      go && REQ.op == `BME_OP_BSB |=> !DONE[*8] ##[1:2] DONE;
   endproperty
   a_bsb: assert property (p_bsb) else $error("branch and set length wrong");
   property p_wait;
      go && (REQ.op == `BME_OP_WAIT_HI || REQ.op == `BME_OP_WAIT_LO) |=> nf[*4];
   endproperty
   a_wait: assert property (p_wait) else $error("wait wrote a flag");
   property p_swap;
      go && REQ.op == `BME_OP_SWAP |=> (nf && !DONE)[*2] ##1 DONE && nf;
   endproperty
   a_swap: assert property (p_swap) else $error("swap length or flags wrong");
   property p_bank;
      go && REQ.op == `BME_OP_BANK_RD |=>
         if ($past(REQ.bank_sel) == `BME_BRG_DTB || $past(REQ.bank_sel) == `BME_BRG_DPR) !DONE ##1 DONE else DONE;
   endproperty
   a_bank: assert property (p_bank) else $error("bank read length wrong");
endmodule : bme_chk
bind bme_unit bme_chk u_bme_chk (.*);
`default_nettype wire

// File: bme_unit_tb.sv
// self-checking bench for the bit-manipulation execution unit
// assumes bme_mem as bus partner and the codes of bme_cfg.svh
`timescale 1ns/100ps
`default_nettype none
`include "bme_cfg.svh"
module bme_unit_tb;
   // ==================================================================
   // stimulus, observation and counters
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic START = 1'b0;
   bme_pkg::bme_req_t REQ = '0;
   logic [31:0] ACC_IN = 32'h0;
   logic [7:0] BANK_IN = 8'h0;
   logic BUSY, DONE, ACC_WE, FLAG_N_WE, FLAG_Z_WE, BRANCH, BUS_RD, BUS_WR, BUS_IO, fwe, br, awe;
   logic [31:0] ACC_OUT;
   bme_pkg::bme_flags_t FLAGS;
   logic [15:0] BUS_ADDR;
   logic [7:0] BUS_WDATA, BUS_RDATA;
   int err_total = 0;
   int checked = 0;
   int n;
   always #25 CLK = ~CLK;
   bme_unit u_bme_unit (.CLK(CLK), .SRST(SRST), .START(START), .REQ(REQ), .ACC_IN(ACC_IN), .BANK_IN(BANK_IN),
      .BUSY(BUSY), .DONE(DONE), .ACC_OUT(ACC_OUT), .ACC_WE(ACC_WE), .FLAGS(FLAGS), .FLAG_N_WE(FLAG_N_WE),
      .FLAG_Z_WE(FLAG_Z_WE), .BRANCH(BRANCH), .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_IO(BUS_IO),
      .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA));
   bme_mem u_bme_mem (.CLK(CLK), .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_IO(BUS_IO), .BUS_ADDR(BUS_ADDR),
      .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA));
   // ==================================================================
   // shared compare, verdict and instruction driver
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task tally_and_finish;
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   // n counts cycles from the taking edge; late pulses caught one cycle on
   task run(input logic [4:0] op, input logic [1:0] am, input logic [15:0] a, input logic [2:0] bp,
      input logic [7:0] rl, input logic [2:0] bs);
      REQ = '{op, am, a, bp, rl, bs};
      START = 1'b1;
      @(posedge CLK);
      #1 START = 1'b0;
      n = 1;
      fwe = FLAG_N_WE | FLAG_Z_WE;
      br = BRANCH;
      awe = ACC_WE;
      while (DONE !== 1'b1) begin
         if (n > 400) begin
            chk("done within bound", 32'h1, 32'h0);
            tally_and_finish;
         end
         @(posedge CLK);
         #1 n++;
         fwe = fwe | FLAG_N_WE | FLAG_Z_WE;
         br = br | BRANCH;
         awe = awe | ACC_WE;
      end
      @(posedge CLK);
      #1 fwe = fwe | FLAG_N_WE | FLAG_Z_WE;
      br = br | BRANCH;
      awe = awe | ACC_WE;
   endtask : run
   // ==================================================================
   // scenarios
   task t_load;
      u_bme_mem.mem[8'h10] = 8'h04;
      run(`BME_OP_BIT_LOAD, `BME_AM_DIR, 16'h0010, 3'h2, 8'h00, 3'h0);
      chk("load cycles", 32'h5, n);
      chk("load acc", 32'h1, ACC_OUT[15:0]);
      chk("load acc write", 32'h1, awe);
      ACC_IN = 32'hFFFFFFFF;
      u_bme_mem.mem[8'h85] = 8'hFB;
      run(`BME_OP_BIT_LOAD, `BME_AM_IO, 16'h0005, 3'h2, 8'h00, 3'h0);
      chk("load io cycles", 32'h4, n);
      chk("load io acc", 32'h0, ACC_OUT[15:0]);
      $display("load done");
   endtask : t_load
   task t_store;
      ACC_IN = 32'h1;
      u_bme_mem.mem[8'h20] = 8'h00;
      run(`BME_OP_BIT_STORE, `BME_AM_A16, 16'h0020, 3'h7, 8'h00, 3'h0);
      chk("store cycles", 32'h7, n);
      chk("store byte", 32'h80, u_bme_mem.mem[8'h20]);
      chk("store flags", 32'h2, FLAGS);
      ACC_IN = 32'h0;
      u_bme_mem.mem[8'hA1] = 8'hFF;
      run(`BME_OP_BIT_STORE, `BME_AM_IO, 16'h0021, 3'h0, 8'h00, 3'h0);
      chk("store io cycles", 32'h6, n);
      chk("store io byte", 32'hFE, u_bme_mem.mem[8'hA1]);
      chk("store io flags", 32'h1, FLAGS);
      $display("store done");
   endtask : t_store
   // all three address forms; neighbouring bits must survive
   task t_setclr;
      logic [7:0] ix;
      for (int m = 0; m < 3; m++) begin
         ix = (m == 2) ? 8'hB0 : 8'h30;
         u_bme_mem.mem[ix] = 8'h00;
         run(`BME_OP_SET, 2'(m), 16'h0030, 3'h3, 8'h00, 3'h0);
         chk("set cycles", 32'h7, n);
         chk("set byte", 32'h08, u_bme_mem.mem[ix]);
         chk("set flag writes", 32'h0, fwe);
         chk("set acc write", 32'h0, awe);
         u_bme_mem.mem[ix] = 8'hFF;
         run(`BME_OP_CLR, 2'(m), 16'h0030, 3'h3, 8'h00, 3'h0);
         chk("clear cycles", 32'h7, n);
         chk("clear byte", 32'hF7, u_bme_mem.mem[ix]);
         chk("clear flag writes", 32'h0, fwe);
      end
      $display("set and clear done");
   endtask : t_setclr
   task t_branch;
      for (int k = 0; k < 2; k++) begin
         for (int m = 0; m < 3; m++) begin
            for (int v = 0; v < 2; v++) begin
               u_bme_mem.mem[(m == 2) ? 8'hC0 : 8'h40] = v ? 8'h40 : 8'hBF;
               run(k ? `BME_OP_BBO : `BME_OP_BBZ, 2'(m), 16'h0040, 3'h6, 8'h00, 3'h0);
               chk("branch cycles", (m == 2 ? 7 : 8) - (k != v), n);
               chk("branch taken", k == v, br);
               chk("branch zero flag", !v, FLAGS.z);
            end
         end
      end
      $display("bit branch done");
   endtask : t_branch
   task t_bsb;
      for (int v = 0; v < 2; v++) begin
         u_bme_mem.mem[8'h50] = v ? 8'h01 : 8'h00;
         run(`BME_OP_BSB, `BME_AM_A16, 16'h0050, 3'h0, 8'h00, 3'h0);
         chk("branch and set cycles", v ? 10 : 9, n);
         chk("branch and set taken", v, br);
         chk("branch and set byte", 32'h01, u_bme_mem.mem[8'h50]);
         chk("branch and set zero flag", !v, FLAGS.z);
      end
      $display("branch and set done");
   endtask : t_bsb
   // the awaited level only appears after 20 cycles
   task t_wait;
      for (int v = 0; v < 2; v++) begin
         u_bme_mem.mem[8'hE0] = v ? 8'h00 : 8'h02;
         fork
            run(v ? `BME_OP_WAIT_HI : `BME_OP_WAIT_LO, `BME_AM_IO, 16'h0060, 3'h1, 8'h00, 3'h0);
            begin
               repeat (20) @(posedge CLK);
               #1 u_bme_mem.mem[8'hE0] = ~u_bme_mem.mem[8'hE0];
            end
         join
         chk("wait stalled", 32'h1, n > 20);
         chk("wait flag writes", 32'h0, fwe);
      end
      $display("wait done");
   endtask : t_wait
   task t_accum;
      ACC_IN = 32'h1234ABCD;
      run(`BME_OP_SWAP, `BME_AM_DIR, 16'h0000, 3'h0, 8'h00, 3'h0);
      chk("swap cycles", 32'h3, n);
      chk("swap acc", 32'hCDAB, ACC_OUT[15:0]);
      chk("swap flag writes", 32'h0, fwe);
      chk("swap acc write", 32'h1, awe);
      for (int s = 0; s < 8; s++) begin
         BANK_IN = 8'hA0 | 8'(s);
         run(`BME_OP_BANK_RD, `BME_AM_DIR, 16'h0000, 3'h0, 8'h00, 3'(s));
         chk("bank cycles", (s == 1 || s == 6) ? 2 : 1, n);
         chk("bank acc", BANK_IN, ACC_OUT[7:0]);
      end
      $display("swap and bank done");
   endtask : t_accum
   task t_stack;
      run(`BME_OP_POP, `BME_AM_DIR, 16'h0000, 3'h0, 8'h00, 3'h0);
      chk("pop empty cycles", 32'h7, n);
      run(`BME_OP_PUSH, `BME_AM_DIR, 16'h0000, 3'h0, 8'h00, 3'h0);
      chk("push empty cycles", 32'h8, n);
      for (int r = 0; r < 8; r++) begin
         run(`BME_OP_POP, `BME_AM_DIR, 16'h0000, 3'h0, 8'h01 << r, 3'h0);
         chk("pop cycles", 10 + 2 * r, n);
         run(`BME_OP_PUSH, `BME_AM_DIR, 16'h0000, 3'h0, 8'h01 << r, 3'h0);
         chk("push cycles", 32 - 3 * r, n);
      end
      $display("stack list done");
   endtask : t_stack
   task t_ext_one(input logic [4:0] op, input logic [31:0] ain, input logic [31:0] mk, input logic [31:0] ex,
      input logic ng);
      ACC_IN = ain;
      run(op, `BME_AM_DIR, 16'h0000, 3'h0, 8'h00, 3'h0);
      chk("extend acc", ex, ACC_OUT & mk);
      chk("extend negative flag", ng, FLAGS.n);
   endtask : t_ext_one
   // ==================================================================
   // reset, then every scenario in turn
   initial begin
      repeat (8) @(posedge CLK);
      #1 SRST = 1'b0;
      @(posedge CLK);
      #1 t_load;
      t_store;
      t_setclr;
      t_branch;
      t_bsb;
      t_wait;
      t_accum;
      t_stack;
      t_ext_one(`BME_OP_EXT, 32'h00000080, 32'h0000FFFF, 32'h0000FF80, 1'b1);
      t_ext_one(`BME_OP_EXTW, 32'h00008000, 32'hFFFFFFFF, 32'hFFFF8000, 1'b1);
      t_ext_one(`BME_OP_ZERO_EXTEND_BYTE, 32'hFFFFFF80, 32'h0000FFFF, 32'h00000080, 1'b0);
      t_ext_one(`BME_OP_ZEXTW, 32'hFFFF8000, 32'hFFFFFFFF, 32'h00008000, 1'b0);
      $display("extend done");
      tally_and_finish;
   end
endmodule : bme_unit_tb
`default_nettype wire
